// ===== twi_master_collision.sv
// Two-wire master: rate counter, repeated start and stop with collision detection
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RULE1: Restart: SDA low at SCL rise collides
// RULE2: Restart: SCL falls before SDA driven collides
// RULE3: Restart: release SDA, count, release SCL, sample
// RULE4: Restart: SDA high reloads; later SDA fall fine
// RULE5: Restart second count: SCL fall collides
// RULE6: Both high: drive SDA, count, drive SCL
// RULE7: Stop: SDA low after timeout collides
// RULE8: Stop: SCL low before SDA high collides
// RULE9: Stop: SDA low, release SCL, count, sample
// RULE10: Rate counter clocks master, reload register value
// RULE11: Buffer write starts the rate counter
// RULE12: Operation done: counter stops, SCL holds
// RULE13: Counter reloads twice per serial clock period
// RULE14: Serial clock is pclk over 4(reload+1)
// RULE15: Software avoids reload values zero to two
// RULE16: Collision sets flag, port returns idle
// RULE17: Collision aborts condition, releases lines, clears request
// RULE18: Counter decrements per tick, times out at zero
// RULE19: Collision interrupt only while enabled; software clears
module twi_master_collision (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             irq
);
  // ******************************
  // Types and state
  // ******************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_TX_LO, ST_TX_HI, ST_RS_REL, ST_RS_SCL, ST_RS_CHK, ST_RS_SDA,
    ST_SP_SDA, ST_SP_SCL, ST_SP_CNT, ST_SP_REL
  } phase_e;

  phase_e      state;
  logic [7:0]  reload;
  logic [7:0]  tx_byte;
  logic [7:0]  shifter;
  logic [3:0]  bit_cnt;
  logic        port_enable;
  logic        restart_request;
  logic        stop_request;
  logic        collision_flag;
  logic        port_irq_flag;
  logic [1:0]  mask;
  logic        load;
  logic        set_col;
  logic        set_done;
  logic [7:0]  cnt;
  logic        run;
  logic [1:0]  pre;
  logic [2:0]  sda_s;
  logic [2:0]  scl_s;
  logic        sda_f;
  logic        scl_f;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        timeout;
  logic        buf_start;
  logic [7:0]  rd_val;

  assign acc       = psel && penable && pready;
  assign wr        = acc && pwrite;
  assign rd        = acc && !pwrite;
  assign tick      = (pre == 2'(twi_rate_pkg::PCLK_PER_TICK - 1));
  assign timeout   = run && tick && (cnt == 8'h00);
  assign buf_start = wr && (paddr == twi_rate_pkg::OFS_BUFFER) && (state == ST_IDLE)
                     && port_enable;

  // ******************************
  // APB slave
  // ******************************
  always_comb begin
    unique case (paddr)
      twi_rate_pkg::OFS_RELOAD:   rd_val = reload;
      twi_rate_pkg::OFS_BUFFER:   rd_val = tx_byte;
      twi_rate_pkg::OFS_CTRL_ONE: rd_val = 8'(port_enable) << twi_rate_pkg::BIT_PORT_ENABLE;
      twi_rate_pkg::OFS_CTRL_TWO: rd_val = (8'(stop_request) << twi_rate_pkg::BIT_STOP_REQUEST)
                                   | (8'(restart_request) << twi_rate_pkg::BIT_RESTART_REQUEST);
      twi_rate_pkg::OFS_STATUS:   rd_val = {(state != ST_IDLE), 5'h00, port_irq_flag,
                                            collision_flag};
      twi_rate_pkg::OFS_MASK:     rd_val = {6'h00, mask};
      default:                    rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? {24'h0, rd_val} : 32'h0;
      pslverr <= psel && penable && !pready && (paddr > twi_rate_pkg::OFS_MASK
                 || paddr[1:0] != 2'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload      <= twi_rate_pkg::RST_RELOAD;
      tx_byte     <= twi_rate_pkg::RST_BYTE;
      port_enable <= 1'b0;
      mask        <= twi_rate_pkg::RST_FLAGS;
    end else if (wr) begin
      if (paddr == twi_rate_pkg::OFS_RELOAD)
        reload <= pwdata[7:0]; // see RULE10
      if (buf_start)
        tx_byte <= pwdata[7:0];
      if (paddr == twi_rate_pkg::OFS_CTRL_ONE)
        port_enable <= pwdata[twi_rate_pkg::BIT_PORT_ENABLE];
      if (paddr == twi_rate_pkg::OFS_MASK)
        mask <= pwdata[1:0];
    end
  end

  // ******************************
  // Interrupt flags
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collision_flag <= 1'b0;
      port_irq_flag  <= 1'b0;
      irq            <= 1'b0;
    end else begin
      // Set wins over the read clear
      if (set_col)
        collision_flag <= 1'b1; // see RULE16
      else if (rd && paddr == twi_rate_pkg::OFS_STATUS)
        collision_flag <= 1'b0; // see RULE19
      if (set_done)
        port_irq_flag <= 1'b1;
      else if (rd && paddr == twi_rate_pkg::OFS_STATUS)
        port_irq_flag <= 1'b0;
      irq <= (collision_flag && mask[twi_rate_pkg::BIT_COLLISION]) // see RULE19
             || (port_irq_flag && mask[twi_rate_pkg::BIT_PORT_IRQ]);
    end
  end

  // ******************************
  // Pin synchronisers
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_s <= 3'h7;
      scl_s <= 3'h7;
      sda_f <= 1'b1;
      scl_f <= 1'b1;
    end else begin
      sda_s <= {sda_s[1:0], sda_in};
      scl_s <= {scl_s[1:0], scl_in};
      if (sda_s[1] == sda_s[2])
        sda_f <= sda_s[2];
      if (scl_s[1] == scl_s[2])
        scl_f <= scl_s[2];
    end
  end

  // ******************************
  // Rate counter
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      run <= 1'b0;
      pre <= 2'h0;
    end else if (state == ST_IDLE) begin
      run <= 1'b0; // see RULE12
      pre <= 2'h0;
    end else if (load) begin
      cnt <= reload; // see RULE13
      run <= 1'b1;
      pre <= 2'h0;
    end else begin
      pre <= tick ? 2'h0 : pre + 2'h1; // see RULE14
      if (timeout)
        run <= 1'b0; // see RULE18
      else if (run && tick)
        cnt <= cnt - 8'h01; // see RULE18
    end
  end

  // ******************************
  // Sequencer
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ST_IDLE;
      sda_oe          <= 1'b0;
      scl_oe          <= 1'b0;
      sda_out         <= 1'b0;
      scl_out         <= 1'b0;
      shifter         <= 8'h00;
      bit_cnt         <= 4'h0;
      restart_request <= 1'b0;
      stop_request    <= 1'b0;
      load            <= 1'b0;
      set_col         <= 1'b0;
      set_done        <= 1'b0;
    end else begin
      load     <= 1'b0;
      set_col  <= 1'b0;
      set_done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (!port_enable) begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
          end else if (buf_start) begin
            shifter <= pwdata[7:0];
            bit_cnt <= 4'h0;
            scl_oe  <= 1'b1;
            sda_oe  <= !pwdata[7];
            load    <= 1'b1; // see RULE11
            state   <= ST_TX_LO;
          end else if (wr && paddr == twi_rate_pkg::OFS_CTRL_TWO) begin
            if (pwdata[twi_rate_pkg::BIT_RESTART_REQUEST]) begin
              restart_request <= 1'b1;
              sda_oe          <= 1'b0;
              load            <= 1'b1; // see RULE3
              state           <= ST_RS_REL;
            end else if (pwdata[twi_rate_pkg::BIT_STOP_REQUEST]) begin
              stop_request <= 1'b1;
              sda_oe       <= 1'b1; // see RULE9
              state        <= ST_SP_SDA;
            end
          end
        end
        ST_TX_LO: if (timeout) begin
          scl_oe <= 1'b0;
          load   <= 1'b1;
          state  <= ST_TX_HI;
        end
        ST_TX_HI: if (timeout) begin
          scl_oe  <= 1'b1;
          bit_cnt <= bit_cnt + 4'h1;
          shifter <= {shifter[6:0], 1'b1};
          if (bit_cnt == 4'(twi_rate_pkg::FRAME_BITS - 1)) begin
            set_done <= 1'b1;
            state    <= ST_IDLE; // see RULE12
          end else begin
            sda_oe <= !shifter[6];
            load   <= 1'b1;
            state  <= ST_TX_LO;
          end
        end
        ST_RS_REL: if (timeout) begin
          scl_oe <= 1'b0; // see RULE3
          state  <= ST_RS_SCL;
        end
        ST_RS_SCL: if (scl_f) begin
          if (!sda_f) begin
            set_col         <= 1'b1; // see RULE1
            restart_request <= 1'b0; // see RULE17
            state           <= ST_IDLE;
          end else begin
            load  <= 1'b1; // see RULE4
            state <= ST_RS_CHK;
          end
        end
        ST_RS_CHK: begin
          if (!scl_f && sda_f) begin
            set_col         <= 1'b1; // see RULE2 RULE5
            restart_request <= 1'b0; // see RULE17
            state           <= ST_IDLE;
          end else if (timeout) begin
            sda_oe <= 1'b1; // see RULE6
            load   <= 1'b1;
            state  <= ST_RS_SDA;
          end
        end
        ST_RS_SDA: if (timeout) begin
          scl_oe          <= 1'b1; // see RULE6
          restart_request <= 1'b0;
          set_done        <= 1'b1;
          state           <= ST_IDLE;
        end
        ST_SP_SDA: if (!sda_f) begin
          scl_oe <= 1'b0; // see RULE9
          state  <= ST_SP_SCL;
        end
        ST_SP_SCL: if (scl_f) begin
          load  <= 1'b1; // see RULE9
          state <= ST_SP_CNT;
        end
        ST_SP_CNT: begin
          if (!scl_f) begin
            set_col      <= 1'b1; // see RULE8
            sda_oe       <= 1'b0; // see RULE17
            stop_request <= 1'b0;
            state        <= ST_IDLE;
          end else if (timeout) begin
            sda_oe <= 1'b0;
            load   <= 1'b1;
            state  <= ST_SP_REL;
          end
        end
        ST_SP_REL: begin
          if (!scl_f && !sda_f) begin
            set_col      <= 1'b1; // see RULE8
            stop_request <= 1'b0;
            state        <= ST_IDLE;
          end else if (timeout) begin
            stop_request <= 1'b0;
            set_col      <= !sda_f; // see RULE7
            set_done     <= sda_f;
            state        <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // Abort releases both lines
      if (state != ST_IDLE && (!port_enable || set_col)) begin
        sda_oe          <= 1'b0; // see RULE17
        scl_oe          <= 1'b0;
        restart_request <= 1'b0;
        stop_request    <= 1'b0;
        state           <= ST_IDLE; // see RULE16
      end
    end
  end

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_col_flag;
    set_col |=> collision_flag;
  endproperty
  a_col_flag: assert property (p_col_flag) else $error("collision flag not set"); // see RULE16

  property p_rs_sda_low;
    (state == ST_RS_SCL && scl_f && !sda_f) |=> set_col ##1 (state == ST_IDLE);
  endproperty
  a_rs_sda_low: assert property (p_rs_sda_low) else $error("restart sda low missed"); // see RULE1

  property p_rs_scl_fall;
    (state == ST_RS_CHK && !scl_f && sda_f) |=> set_col && !restart_request;
  endproperty
  a_rs_scl_fall: assert property (p_rs_scl_fall) else $error("restart scl fall missed"); // see RULE5

  property p_rs_sda_driven;
    (state == ST_RS_SDA) |-> sda_oe && !scl_oe;
  endproperty
  a_rs_sda_driven: assert property (p_rs_sda_driven) else $error("restart sda not driven"); // see RULE6

  property p_col_release;
    set_col |=> !sda_oe && !scl_oe && !stop_request && !restart_request;
  endproperty
  a_col_release: assert property (p_col_release) else $error("lines not released"); // see RULE17

  property p_sp_sda_low;
    (state == ST_SP_REL && timeout && !sda_f && scl_f) |=> set_col;
  endproperty
  a_sp_sda_low: assert property (p_sp_sda_low) else $error("stop sda low missed"); // see RULE7

  property p_sp_scl_low;
    (state == ST_SP_CNT && !scl_f && port_enable) |=> set_col;
  endproperty
  a_sp_scl_low: assert property (p_sp_scl_low) else $error("stop scl low missed"); // see RULE8

  property p_buf_start;
    buf_start |=> (state == ST_TX_LO) ##1 (run && cnt == reload);
  endproperty
  a_buf_start: assert property (p_buf_start) else $error("buffer write no start"); // see RULE11

  property p_idle_stops;
    (state == ST_IDLE)[*2] |-> !run;
  endproperty
  a_idle_stops: assert property (p_idle_stops) else $error("counter runs in idle"); // see RULE12
  property p_irq_gate;
    (collision_flag && mask[0]) |=> irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not raised"); // see RULE19

  c_restart_done: cover property ((state == ST_RS_SDA) ##1 (state == ST_IDLE));
  c_stop_col:     cover property ((state == ST_SP_REL) ##1 set_col);
  c_tx_done:      cover property ((state == ST_TX_HI) ##1 set_done);
endmodule : twi_master_collision
`default_nettype wire

// ===== twi_rate_pkg.sv
// Register map, field positions and timing constants of the two-wire master
package twi_rate_pkg;
  localparam logic [7:0] OFS_RELOAD    = 8'h00;
  localparam logic [7:0] OFS_BUFFER    = 8'h04;
  localparam logic [7:0] OFS_CTRL_ONE  = 8'h08;
  localparam logic [7:0] OFS_CTRL_TWO  = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_MASK      = 8'h14;

  localparam int BIT_PORT_ENABLE       = 5;
  localparam int BIT_STOP_REQUEST      = 2;
  localparam int BIT_RESTART_REQUEST   = 1;
  localparam int BIT_COLLISION         = 0;
  localparam int BIT_PORT_IRQ          = 1;
  localparam int BIT_BUSY              = 7;

  localparam logic [7:0] RST_RELOAD    = 8'h00;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [1:0] RST_FLAGS     = 2'h0;

  // pclk cycles per rate counter decrement
  localparam int PCLK_PER_TICK         = 2;
  localparam int FRAME_BITS            = 9;
endpackage : twi_rate_pkg

// ===== twi_bus_peer.sv
// Shared two-wire bus with pull-ups and a second master that can pull either line
`timescale 1ns/1ns
`default_nettype none
module twi_bus_peer (
  input  wire logic sda_oe,
  input  wire logic scl_oe,
  input  wire logic other_sda_low,
  input  wire logic other_scl_low,
  output logic      sda,
  output logic      scl
);
  // Wired-AND, a released line floats high
  assign sda = !(sda_oe || other_sda_low);
  assign scl = !(scl_oe || other_scl_low);
endmodule : twi_bus_peer
`default_nettype wire

// ===== tb.sv
// Testbench: registers, byte timing, restart and stop with collisions
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, sda_out, sda_oe, scl_out, scl_oe, irq, sda, scl, e;
  logic        peer_sda = 0;
  logic        peer_scl = 0;
  logic        start_seen, stop_seen;
  logic [7:0]  rl, got;
  int          bad_count = 0, num_checks = 0, seed = 3, t0, per, c, f;
  always #5 pclk = ~pclk;
  twi_master_collision dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));
  twi_bus_peer peer_u (.sda_oe(sda_oe), .scl_oe(scl_oe), .other_sda_low(peer_sda),
    .other_scl_low(peer_scl), .sda(sda), .scl(scl));
  always @(negedge sda) if (scl === 1'b1) start_seen = 1;
  always @(posedge sda) if (scl === 1'b1) stop_seen = 1;
  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    num_checks++;
    if (gv !== ev) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, gv, ev);
    end
  endtask : chk
  task automatic chk_rng(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask : chk_rng
  // Bounded wait on scl (0), sda (1) or irq (2)
  task automatic wt(input int w, input logic lv);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge pclk);
      if ((w == 0 ? scl : w == 1 ? sda : irq) === lv) return;
    end
    chk(n, 0);
    close_out();
  endtask : wt
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 20) begin
      chk(n, 0);
      close_out();
    end
  endtask : apb
  function automatic int exp_per(input logic [7:0] v);
    return 4 * (int'(v) + 1);
  endfunction : exp_per
  function automatic logic [1:0] exp_st(input int fv);
    return (fv == 1 || fv == 2) ? 2'b01 : 2'b10;
  endfunction : exp_st
  function automatic logic [1:0] exp_lines(input int cv, input int fv);
    if (fv == 1 || fv == 2) return 2'b00;
    return cv == 0 ? 2'b11 : 2'b00;
  endfunction : exp_lines
  task automatic do_byte(input logic [7:0] bv);
    int i;
    apb(1, twi_rate_pkg::OFS_BUFFER, {24'h0, bv});
    for (i = 0; i < 9; i++) begin
      wt(0, 0);
      wt(0, 1);
      if (i < 8) got = {got[6:0], sda};
      if (i == 1) t0 = $time;
      if (i == 2) per = ($time - t0) / 10;
    end
    wt(2, 1);
    apb(0, twi_rate_pkg::OFS_STATUS, 0);
    chk(r, 32'h2);
    chk(got, bv);
    chk_rng(per, exp_per(rl), exp_per(rl) + 4);
    repeat (20) @(posedge pclk);
    chk(scl_oe, 1);
  endtask : do_byte
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, twi_rate_pkg::OFS_RELOAD, 0);
    chk(r, 0);
    apb(0, twi_rate_pkg::OFS_STATUS, 0);
    chk(r, 0);
    apb(0, 8'h18, 0);
    chk({e, r[7:0]}, 9'h100);
    apb(1, twi_rate_pkg::OFS_BUFFER, 32'h5a);
    apb(0, twi_rate_pkg::OFS_BUFFER, 0);
    chk({scl_oe, r[7:0]}, 9'h000);
    rl = 8'(4 + {$random(seed)} % 8);
    apb(1, twi_rate_pkg::OFS_RELOAD, {24'h0, rl});
    apb(0, twi_rate_pkg::OFS_RELOAD, 0);
    chk(r, {24'h0, rl});
    apb(1, twi_rate_pkg::OFS_CTRL_ONE, 32'h20);
    apb(1, twi_rate_pkg::OFS_MASK, 32'h3);
    do_byte(8'h80);
    do_byte(8'($random(seed)));
    for (c = 0; c < 2; c++) for (f = 0; f < 4; f++) begin
      if (c == 1 && f == 3) continue;
      do_byte(8'($random(seed)));
      start_seen = 0;
      stop_seen = 0;
      peer_sda <= (f == 1);
      apb(1, twi_rate_pkg::OFS_CTRL_TWO, c ? 32'h4 : 32'h2);
      if (f == 0) begin
        apb(0, twi_rate_pkg::OFS_CTRL_TWO, 0);
        chk(r, c ? 32'h4 : 32'h2);
      end
      if (f >= 2) begin
        wt(0, 1);
        repeat (f == 2 ? 4 : 7) @(posedge pclk);
        if (f == 2) peer_scl <= 1;
        else peer_sda <= 1;
      end
      wt(2, 1);
      apb(0, twi_rate_pkg::OFS_STATUS, 0);
      chk(r[1:0], exp_st(f));
      peer_sda <= 0;
      peer_scl <= 0;
      chk({sda_oe, scl_oe}, exp_lines(c, f));
      chk({sda_out, scl_out}, 2'b00);
      apb(0, twi_rate_pkg::OFS_CTRL_TWO, 0);
      chk(r, 0);
      if (f == 0) chk(c ? stop_seen : start_seen, 1);
      chk(irq, 0);
    end
    apb(1, twi_rate_pkg::OFS_MASK, 32'h2);
    do_byte(8'h01);
    peer_sda <= 1;
    apb(1, twi_rate_pkg::OFS_CTRL_TWO, 32'h2);
    repeat (300) @(posedge pclk);
    chk(irq, 0);
    apb(0, twi_rate_pkg::OFS_STATUS, 0);
    chk(r[0], 1);
    peer_sda <= 0;
    close_out();
  end
endmodule : tb
`default_nettype wire
